// ===== hw/drd_pkg.sv
package drd_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int WIN_OFF_W = 12;
    // component windows, base and last address
    localparam logic [31:0] PPB_BASE = 32'he000_0000;
    localparam logic [31:0] PPB_LAST = 32'he00f_ffff;
    localparam logic [31:0] SWT_BASE = 32'he000_0000;
    localparam logic [31:0] SWT_LAST = 32'he000_0fff;
    localparam logic [31:0] WTU_BASE = 32'he000_1000;
    localparam logic [31:0] WTU_LAST = 32'he000_1fff;
    localparam logic [31:0] PBU_BASE = 32'he000_2000;
    localparam logic [31:0] PBU_LAST = 32'he000_2fff;
    localparam logic [31:0] SCS_BASE = 32'he000_ed00;
    localparam logic [31:0] SCS_LAST = 32'he000_efff;
    localparam logic [31:0] SCB_BASE = 32'he000_ed00;
    localparam logic [31:0] SCB_LAST = 32'he000_ed8f;
    localparam logic [31:0] DCB_BASE = 32'he000_edf0;
    localparam logic [31:0] DCB_LAST = 32'he000_eeff;
    localparam logic [31:0] TPU_BASE = 32'he004_0000;
    localparam logic [31:0] TPU_LAST = 32'he004_0fff;
    localparam logic [31:0] ITU_BASE = 32'he004_1000;
    localparam logic [31:0] ITU_LAST = 32'he004_1fff;
    localparam logic [31:0] IDT_BASE = 32'he00f_f000;
    localparam logic [31:0] IDT_LAST = 32'he00f_ffff;
    // identification table entry offsets, word per component
    localparam logic [11:0] IDT_ENT_SWT = 12'h000;
    localparam logic [11:0] IDT_ENT_WTU = 12'h004;
    localparam logic [11:0] IDT_ENT_PBU = 12'h008;
    localparam logic [11:0] IDT_ENT_TPU = 12'h00c;
    localparam logic [11:0] IDT_ENT_ITU = 12'h010;
    localparam int PRESENT_BIT = 0;
    // selected target encoding
    typedef enum logic [3:0] {
        DRD_SEL_NONE,
        DRD_SEL_SWT,
        DRD_SEL_WTU,
        DRD_SEL_PBU,
        DRD_SEL_SCB,
        DRD_SEL_DCB,
        DRD_SEL_SCS,
        DRD_SEL_TPU,
        DRD_SEL_ITU,
        DRD_SEL_IDT
    } drd_sel_type;
endpackage : drd_pkg

// ===== hw/drd_decoder.sv
// Operation
// [RULE1] debug resources live in private peripheral region
// [RULE2] fixed 4KB windows, low bits as offset; the SCS window is E000ED00-E000EFFF here, with smaller SCB and DCB subblocks
// [RULE3] E0000000-E0000FFF selects sw trace unit
// [RULE4] E0001000-E0001FFF selects watch trace unit
// [RULE5] E0002000-E0002FFF selects patch break unit
// [RULE6] E000ED00-E000EFFF selects system control space
// [RULE7] ED00-ED8F decodes system control subblock
// [RULE8] EDF0-EEFF decodes debug control subblock
// [RULE9] E0040000-E0040FFF selects trace port unit
// [RULE10] shared trace port window stays reserved
// [RULE11] E0041000-E0041FFF selects instr trace unit
// [RULE12] E00FF000-E00FFFFF selects identification table
// [RULE13] table tells software which components exist
// [RULE14] debug port works running, halted, in reset
// [RULE15] halted processor reported as debug state; DEBUG_STATE stays low while CORE_IN_RESET
// [RULE16] sw trace writes never stall master
// [RULE17] trace exported through local or external sink
// [RULE18] optional components configured per implementation
// [RULE19] unmapped or absent windows select nothing
// [RULE20] table entry bit 0 shows presence
`timescale 1ns/1ps
`default_nettype none
module drd_decoder
    import drd_pkg::*;
#(
    parameter bit HAS_SWT = 1'b1,
    parameter bit HAS_WTU = 1'b1,
    parameter bit HAS_PBU = 1'b1,
    parameter bit HAS_TPU = 1'b1,
    parameter bit TPU_SHARED = 1'b0,
    parameter bit HAS_ITU = 1'b1
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESETN,
    // debug port master
    input wire logic DP_REQ,
    input wire logic DP_WRITE,
    input wire logic [drd_pkg::ADDR_W-1:0] DP_ADDR,
    input wire logic [drd_pkg::DATA_W-1:0] DP_WDATA,
    output logic DP_READY,
    output logic DP_ERR,
    output logic [drd_pkg::DATA_W-1:0] DP_RDATA,
    // processor bus master
    input wire logic CPU_REQ,
    input wire logic CPU_WRITE,
    input wire logic [drd_pkg::ADDR_W-1:0] CPU_ADDR,
    input wire logic [drd_pkg::DATA_W-1:0] CPU_WDATA,
    output logic CPU_READY,
    output logic CPU_ERR,
    output logic [drd_pkg::DATA_W-1:0] CPU_RDATA,
    // core status
    input wire logic CORE_HALTED,
    input wire logic CORE_IN_RESET,
    output logic DEBUG_STATE,
    // component side
    output logic [3:0] COMP_SEL,
    output logic COMP_VALID,
    output logic COMP_WRITE,
    output logic [drd_pkg::WIN_OFF_W-1:0] COMP_OFFSET,
    output logic [drd_pkg::DATA_W-1:0] COMP_WDATA,
    output logic COMP_FROM_DP,
    input wire logic COMP_READY,
    input wire logic [drd_pkg::DATA_W-1:0] COMP_RDATA,
    // trace sink routing
    output logic TRACE_TO_LOCAL
);
    import drd_pkg::*;

    function automatic logic in_win(input logic [31:0] a,
            input logic [31:0] lo, input logic [31:0] hi);
        in_win = (a >= lo) && (a <= hi);
    endfunction : in_win

    function automatic drd_sel_type decode(input logic [31:0] a);
        decode = DRD_SEL_NONE; // RULE19
        if (in_win(a, PPB_BASE, PPB_LAST)) begin // RULE1
            if (in_win(a, SWT_BASE, SWT_LAST) && HAS_SWT)
                decode = DRD_SEL_SWT; // RULE3
            else if (in_win(a, WTU_BASE, WTU_LAST) && HAS_WTU)
                decode = DRD_SEL_WTU; // RULE4
            else if (in_win(a, PBU_BASE, PBU_LAST) && HAS_PBU)
                decode = DRD_SEL_PBU; // RULE5
            else if (in_win(a, SCB_BASE, SCB_LAST))
                decode = DRD_SEL_SCB; // RULE7
            else if (in_win(a, DCB_BASE, DCB_LAST))
                decode = DRD_SEL_DCB; // RULE8
            else if (in_win(a, SCS_BASE, SCS_LAST))
                decode = DRD_SEL_SCS; // RULE6
            else if (in_win(a, TPU_BASE, TPU_LAST) && HAS_TPU
                    && !TPU_SHARED)
                decode = DRD_SEL_TPU; // RULE9 RULE10
            else if (in_win(a, ITU_BASE, ITU_LAST) && HAS_ITU)
                decode = DRD_SEL_ITU; // RULE11
            else if (in_win(a, IDT_BASE, IDT_LAST))
                decode = DRD_SEL_IDT; // RULE12
        end
    endfunction : decode

    function automatic logic [31:0] id_entry(input logic [11:0] off);
        id_entry = '0;
        unique case (off)
            IDT_ENT_SWT: id_entry[PRESENT_BIT] = HAS_SWT; // RULE20
            IDT_ENT_WTU: id_entry[PRESENT_BIT] = HAS_WTU;
            IDT_ENT_PBU: id_entry[PRESENT_BIT] = HAS_PBU;
            IDT_ENT_TPU: id_entry[PRESENT_BIT] = HAS_TPU && !TPU_SHARED;
            IDT_ENT_ITU: id_entry[PRESENT_BIT] = HAS_ITU;
            default: id_entry = '0;
        endcase
    endfunction : id_entry

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_DONE
    } drd_state_type;

    drd_state_type state;
    logic owner_dp;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic err;
    drd_sel_type sel;
    drd_sel_type next_sel;
    logic posted;

    // debug port wins so it is never starved by the core; RULE14
    logic take_dp;
    logic take_any;
    logic [31:0] req_addr;
    assign take_dp = DP_REQ;
    assign take_any = DP_REQ || CPU_REQ;
    assign req_addr = take_dp ? DP_ADDR : CPU_ADDR;
    assign next_sel = decode(req_addr);

    // sw trace writes are posted, done the cycle after the wait state without component ready
    assign posted = (sel == DRD_SEL_SWT) && write; // RULE16

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: if (take_any) state <= ST_WAIT;
                ST_WAIT: begin
                    if (sel == DRD_SEL_NONE || sel == DRD_SEL_IDT
                            || posted || COMP_READY)
                        state <= ST_DONE;
                end
                ST_DONE: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            owner_dp <= 1'b0;
            write <= 1'b0;
            addr <= '0;
            wdata <= '0;
            sel <= DRD_SEL_NONE;
        end else if (state == ST_IDLE && take_any) begin
            owner_dp <= take_dp;
            write <= take_dp ? DP_WRITE : CPU_WRITE;
            addr <= req_addr;
            wdata <= take_dp ? DP_WDATA : CPU_WDATA;
            sel <= next_sel;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata <= '0;
            err <= 1'b0;
        end else if (state == ST_WAIT) begin
            err <= (sel == DRD_SEL_NONE); // RULE19
            if (write || sel == DRD_SEL_NONE)
                rdata <= '0;
            else if (sel == DRD_SEL_IDT)
                rdata <= id_entry(addr[WIN_OFF_W-1:0]); // RULE13
            else
                rdata <= COMP_RDATA;
        end
    end

    // component request stands while waiting
    always_comb begin
        COMP_VALID = (state == ST_WAIT) && sel != DRD_SEL_NONE
            && sel != DRD_SEL_IDT;
        COMP_SEL = sel;
        COMP_WRITE = write;
        COMP_OFFSET = addr[WIN_OFF_W-1:0]; // RULE2
        COMP_WDATA = wdata;
        COMP_FROM_DP = owner_dp;
    end

    // answers
    always_comb begin
        DP_READY = (state == ST_DONE) && owner_dp;
        CPU_READY = (state == ST_DONE) && !owner_dp;
        DP_ERR = DP_READY && err;
        CPU_ERR = CPU_READY && err;
        DP_RDATA = rdata;
        CPU_RDATA = rdata;
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            DEBUG_STATE <= 1'b0;
        end else begin
            DEBUG_STATE <= CORE_HALTED && !CORE_IN_RESET; // RULE15
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            TRACE_TO_LOCAL <= 1'b0;
        end else begin
            TRACE_TO_LOCAL <= HAS_TPU && !TPU_SHARED; // RULE17 RULE18
        end
    end
endmodule : drd_decoder
`default_nettype wire

// ===== dv/drd_decoder_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module drd_decoder_asserts
    import drd_pkg::*;
(
    input wire logic CORE_CLK, RESETN, DP_REQ, CPU_REQ,
    input wire logic DP_READY, DP_ERR, CPU_READY,
    input wire logic CORE_HALTED, CORE_IN_RESET, DEBUG_STATE,
    input wire logic COMP_VALID, COMP_WRITE, COMP_READY,
    input wire logic [31:0] DP_RDATA,
    input wire logic [3:0] COMP_SEL
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    sequence s_done; DP_READY || CPU_READY; endsequence
    sequence s_post; COMP_VALID && COMP_WRITE && COMP_SEL == 4'h1; endsequence
    property p_dp_pulse; DP_READY |=> !DP_READY; endproperty
    a_dp_pulse: assert property (p_dp_pulse) else $error("ready too long");
    property p_err_none; DP_READY && COMP_SEL == 4'h0 |-> DP_ERR; endproperty
    a_err_none: assert property (p_err_none) else $error("no err");
    property p_err_data; DP_READY && DP_ERR |-> DP_RDATA == 32'h0; endproperty
    a_err_data: assert property (p_err_data) else $error("err data");
    property p_post; s_post |=> s_done; endproperty
    a_post: assert property (p_post) else $error("write blocked");
    property p_comp; COMP_VALID && COMP_READY |=> s_done; endproperty
    a_comp: assert property (p_comp) else $error("no completion");
    property p_wait;
        COMP_VALID && !COMP_READY && !COMP_WRITE |=> !DP_READY && !CPU_READY;
    endproperty
    a_wait: assert property (p_wait) else $error("early ready");
    property p_lat; $rose(DP_REQ) |=> !DP_READY ##[1:40] DP_READY; endproperty
    a_lat: assert property (p_lat) else $error("dp latency");
    property p_dbg; CORE_HALTED && !CORE_IN_RESET |=> DEBUG_STATE; endproperty
    a_dbg: assert property (p_dbg) else $error("debug state");
endmodule : drd_decoder_asserts
`default_nettype wire

// ===== dv/drd_comp_model.sv
`timescale 1ns/1ps
`default_nettype none
module drd_comp_model (
    // clock and reset
    input wire logic CORE_CLK, RESETN,
    // component side
    input wire logic COMP_VALID,
    input wire logic [3:0] COMP_SEL,
    input wire logic [11:0] COMP_OFFSET,
    input wire logic [3:0] wait_cyc,
    output logic COMP_READY,
    output logic [31:0] COMP_RDATA
);
    logic [3:0] cnt;
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) cnt <= 4'h0;
        else if (COMP_VALID && !COMP_READY) cnt <= cnt + 4'h1;
        else cnt <= 4'h0;
    end
    assign COMP_READY = COMP_VALID && cnt >= wait_cyc;
    // data only meaningful with ready, inverted pattern otherwise
    assign COMP_RDATA = COMP_READY ? {16'ha5a5, COMP_SEL, COMP_OFFSET}
                                   : {16'h5a5a, ~COMP_SEL, ~COMP_OFFSET};
endmodule : drd_comp_model
`default_nettype wire

// ===== dv/drd_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module drd_decoder_tb;
    import drd_pkg::*;
    logic CORE_CLK = 0, RESETN = 0, CORE_HALTED = 0, CORE_IN_RESET = 0;
    logic DP_REQ = 0, DP_WRITE = 0, CPU_REQ = 0, CPU_WRITE = 0;
    logic [31:0] DP_ADDR = 0, DP_WDATA = 0, CPU_ADDR = 0, CPU_WDATA = 0;
    logic DP_READY, DP_ERR, CPU_READY, CPU_ERR, DEBUG_STATE, er;
    logic COMP_VALID, COMP_WRITE, COMP_FROM_DP, COMP_READY, TRACE_TO_LOCAL;
    logic [31:0] DP_RDATA, CPU_RDATA, COMP_WDATA, COMP_RDATA, rd, exp;
    logic [3:0] COMP_SEL, wait_cyc = 0;
    logic [11:0] COMP_OFFSET;
    int fail_count = 0, n_tests = 0, lat;
    always #2 CORE_CLK = ~CORE_CLK;
    drd_decoder dut (.*);
    drd_comp_model model (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            fail_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, want);
        end
    endtask : chk
    task automatic xfer(input bit cpu, input bit wr, input logic [31:0] a);
        lat = 0;
        @(posedge CORE_CLK);
        {DP_ADDR, CPU_ADDR, DP_WDATA, CPU_WDATA} <= {a, a, ~a, ~a};
        {DP_WRITE, CPU_WRITE, CPU_REQ, DP_REQ} <= {wr, wr, cpu, !cpu};
        do @(negedge CORE_CLK);
        while ((cpu ? CPU_READY : DP_READY) !== 1'b1 && lat++ < 60);
        chk(lat <= 60, 1);
        rd = cpu ? CPU_RDATA : DP_RDATA;
        er = cpu ? CPU_ERR : DP_ERR;
        @(posedge CORE_CLK);
        {CPU_REQ, DP_REQ} <= 2'b00;
    endtask : xfer
    task automatic t_map;
        logic [31:0] tab [19] = '{32'he0000000, 32'he0000fff, 32'he0001000,
            32'he0002fff, 32'he000ed00, 32'he000ed8f, 32'he000ed90,
            32'he000edf0, 32'he000eeff, 32'he000efff, 32'he0040000,
            32'he0041fff, 32'he00ff000, 32'he00ff010, 32'he00fffff,
            32'he0003000, 32'he000ecff, 32'he0042000, 32'he00feffc};
        logic [3:0] sel [19] = '{1, 1, 2, 3, 4, 4, 6, 5, 5, 6, 7, 8, 9, 9, 9,
            0, 0, 0, 0};
        for (int i = 0; i < 19; i++) begin
            xfer(i[0], 1'b0, tab[i]);
            exp = sel[i] == 4'h0 ? 32'h0 : {16'ha5a5, sel[i], tab[i][11:0]};
            if (sel[i] == 4'h9) exp = {31'h0, tab[i][11:0] inside {0, 16}};
            chk(COMP_SEL, sel[i]);
            chk(rd, exp);
            chk(er, sel[i] == 4'h0);
            if (er === 1'b0) chk(COMP_OFFSET, tab[i][11:0]);
        end
    endtask : t_map
    task automatic t_post;
        wait_cyc <= 4'h6;
        xfer(1'b1, 1'b1, 32'he0000010);
        chk(lat, 2);
        chk(COMP_WDATA, 32'h1fff_ffef);
        chk(COMP_WRITE, 1);
        chk(COMP_FROM_DP, 0);
        xfer(1'b0, 1'b0, 32'he0001008);
        chk(lat, 8);
        chk(COMP_FROM_DP, 1);
        chk(COMP_WRITE, 0);
        chk(rd, 32'ha5a52008);
        wait_cyc <= 4'h0;
    endtask : t_post
    task automatic t_core;
        CORE_HALTED <= 1'b1;
        xfer(1'b0, 1'b0, 32'he00ff004);
        chk(DEBUG_STATE, 1);
        chk(rd, 1);
        CORE_IN_RESET <= 1'b1;
        xfer(1'b0, 1'b0, 32'he00ff00c);
        chk(DEBUG_STATE, 0);
        chk(rd, 1);
        chk(TRACE_TO_LOCAL, 1);
    endtask : t_core
    task automatic summarize;
        if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    initial begin
        repeat (3) @(posedge CORE_CLK);
        RESETN <= 1'b1;
        t_map();
        t_post();
        t_core();
        summarize();
    end
    initial begin
        #40000;
        fail_count++;
        summarize();
    end
endmodule : drd_decoder_tb
bind drd_decoder drd_decoder_asserts chk_i (.*);
`default_nettype wire
